// ### logic/data_break_link.sv
// What this block does
// RQ1 - Slot 0 compare register, full read/write
// RQ2 - Slot 1 is mask or second address
// RQ3 - Mask bits drop out of slot 0 compare
// RQ4 - Mask ignores slot 1 enable, needs slot 0
// RQ5 - Second slot matches alone by own type
// RQ6 - Fire on type match and any byte hit
// RQ7 - Types any and load both include loads
// RQ8 - Preload and cache maintenance never fire
// RQ9 - Atomic swaps count as stores
// RQ10 - Unaligned address rounds down to word
// RQ11 - Report after issue, never abort access
// RQ12 - Debug exception, entry reason data break
// RQ13 - Return link is next pc plus four
// RQ14 - Soft break needs global enable, else no-op
// RQ15 - Handler flags in link control register
// RQ16 - Flags sit on condition flag positions
// RQ17 - Debugger polls full before writing word
// RQ18 - Debugger write sets inbound full
// RQ19 - Handler read of inbound clears full
// RQ20 - Download write sets full and download
// RQ21 - Write while full sets lost word flag
// RQ22 - Download flag follows debugger, handler loops
// RQ23 - Lost flag sticky until control write
`timescale 1ns/1ns
`include "dbg_cfg.svh"

module data_break_link (
  input  wire logic         clock,
  input  wire logic         arst_n,
  // Access port from the core pipeline
  input  wire dbg_pkg::acc_s acc,
  output      logic         dbg_exception,
  output      logic [31:0]  return_link,
  // Test port pins
  input  wire dbg_pkg::pin_s pins,
  output      logic         link_tdo,
  // AXI4-Lite slave
  input  wire logic [31:0]  s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output      logic         s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output      logic         s_axi_wready,
  output      logic [1:0]   s_axi_bresp,
  output      logic         s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [31:0]  s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output      logic         s_axi_arready,
  output      logic [31:0]  s_axi_rdata,
  output      logic [1:0]   s_axi_rresp,
  output      logic         s_axi_rvalid,
  input  wire logic         s_axi_rready
);

  logic [1:0]       rst_pipe;   // Reset release pipe
  logic             rst_n;      // Released reset used by the state register and the checks
  dbg_pkg::state_s  st;         // Registered state
  dbg_pkg::state_s  next_st;    // Next state
  logic [31:0]      base;       // Access address after rounding
  logic [2:0]       nbytes;     // Bytes touched by the access
  logic [31:0]      mask;       // Bits left out of slot 0 compare
  logic [3:0]       hit0;       // Per byte hit on slot 0
  logic [3:0]       hit1;       // Per byte hit on slot 1
  logic             is_load;    // Access is a load, swaps excluded
  logic             is_store;   // Access writes memory
  logic             eligible;   // Access may trigger at all
  logic             slot0_hit;  // Slot 0 fires
  logic             slot1_hit;  // Slot 1 fires
  logic             data_hit;   // Any data break this cycle
  dbg_pkg::pin_s    settled;    // Pins after the agree filter
  logic             tck_rise;   // Settled test clock rising edge
  logic             link_wr;    // Debugger update into inbound buffer
  logic             inb_rd;     // Handler read of inbound buffer
  logic             ctl_wr;     // Handler write of link control

  // Reset release through two flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // Access type check for one slot
  function automatic logic type_ok(input logic [1:0] t, input logic ld, input logic sto);
    // RQ7 any and load types
    type_ok = ((t == `ATYPE_STORE) && sto) || ((t == `ATYPE_ANY) && (ld || sto)) ||
              ((t == `ATYPE_LOAD) && ld);
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  // Access classification
  always_comb begin
    // RQ9 swaps as stores
    is_load  = (acc.kind == dbg_pkg::ACC_LOAD);
    is_store = (acc.kind == dbg_pkg::ACC_STORE) || (acc.kind == dbg_pkg::ACC_SWAP);
    // RQ8 preload excluded
    eligible = acc.valid && (acc.kind != dbg_pkg::ACC_PRELOAD) &&
               (acc.kind != dbg_pkg::ACC_CP_MAINT);
    nbytes   = 3'h1 << acc.size;
    // RQ10 round down unaligned
    if (((acc.size == 2'h1) && acc.addr[0]) || ((acc.size == 2'h2) && (acc.addr[1:0] != 2'h0))) begin
      base = {acc.addr[31:2], 2'h0};
    end else begin
      base = acc.addr;
    end
    // RQ3 mask when mask mode
    mask = st.mask_mode ? st.cmp1 : `RST_WORD;
  end

  // Per byte address comparison
  for (genvar gi = 0; gi < 4; gi++) begin : g_byte
    logic [31:0] byte_addr;  // Address of this byte
    logic        in_acc;     // Byte is part of the access
    assign byte_addr = base + 32'(gi);
    assign in_acc    = (3'(gi) < nbytes);
    // RQ6 any byte hit
    assign hit0[gi]  = in_acc && (((byte_addr ^ st.cmp0) & ~mask) == `RST_WORD);
    assign hit1[gi]  = in_acc && (byte_addr == st.cmp1);
  end

  // Slot decisions
  always_comb begin
    // RQ4 mask only with slot 0
    slot0_hit = eligible && type_ok(st.e0, is_load, is_store) && (hit0 != 4'h0);
    // RQ5 independent second slot
    slot1_hit = eligible && !st.mask_mode && type_ok(st.e1, is_load, is_store) &&
                (hit1 != 4'h0);
    data_hit  = slot0_hit || slot1_hit;
  end

  // Test clock edge, update strobe and bus strobes
  always_comb begin
    // Filter built from stages two and three and the registered stable value, so no loop through next_st
    settled  = (st.s2 & st.s3) | (st.stable & (st.s2 ^ st.s3));
    tck_rise = settled.tck && !st.stable.tck;
    link_wr  = tck_rise && st.stable.sel && st.stable.upd;
    inb_rd   = s_axi_arvalid && st.ar_rdy && (s_axi_araddr[7:0] == `OFS_INBOUND);
    ctl_wr   = st.aw_have && st.w_have && (st.aw_addr == `OFS_LINK_CTL);
  end

  // Next state of the whole block
  always_comb begin
    next_st = st;
    // Pin synchronisers; a change counts when stages two and three agree
    next_st.s1     = pins;
    next_st.s2     = st.s1;
    next_st.s3     = st.s2;
    next_st.stable = settled;

    // RQ11 report after issue
    next_st.exc = 1'b0;
    if (data_hit) begin
      // RQ12 data break reason
      next_st.exc = 1'b1;
      next_st.moe = `MOE_DATA;
      // RQ13 next pc plus four
      next_st.ret_link = acc.next_pc + `LINK_OFS;
    end else if (acc.soft_break && st.ge) begin
      // RQ14 soft break when enabled
      next_st.exc      = 1'b1;
      next_st.moe      = `MOE_SOFT;
      next_st.ret_link = acc.next_pc + `LINK_OFS;
    end

    // Test port shift register, capture loads flags for polling
    if (tck_rise && st.stable.sel) begin
      if (st.stable.cap) begin
        // RQ17 full flag shifts out first
        next_st.shreg = {32'h0000_0000, st.lost, st.full};
      end else if (!st.stable.upd) begin
        next_st.shreg = {st.stable.tdi, st.shreg[33:1]};
      end
      next_st.tdo = next_st.shreg[0];
    end

    // Write address channel
    if (s_axi_awvalid && st.aw_rdy) begin
      next_st.aw_have = 1'b1;
      next_st.aw_addr = s_axi_awaddr[7:0];
    end
    // Write data channel
    if (s_axi_wvalid && st.w_rdy) begin
      next_st.w_have = 1'b1;
      next_st.wdata  = s_axi_wdata;
      next_st.wstrb  = s_axi_wstrb;
    end
    // Response handshake
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    // Register write once both halves are held
    if (st.aw_have && st.w_have) begin
      next_st.aw_have = 1'b0;
      next_st.w_have  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = `RESP_OKAY;
      case (st.aw_addr)
        // RQ1 slot 0 register
        `OFS_CMP0: begin
          next_st.cmp0 = merge(st.cmp0, st.wdata, st.wstrb);
        end
        // RQ2 mask or second slot
        `OFS_CMP1: begin
          next_st.cmp1 = merge(st.cmp1, st.wdata, st.wstrb);
        end
        `OFS_BRK_CTL: begin
          if (st.wstrb[0]) begin
            next_st.e0 = st.wdata[`BRK_E0_LSB +: 2];
            next_st.e1 = st.wdata[`BRK_E1_LSB +: 2];
          end
          if (st.wstrb[1]) begin
            next_st.mask_mode = st.wdata[`BRK_MASK_BIT];
          end
        end
        `OFS_DBG_CTL: begin
          if (st.wstrb[3]) begin
            next_st.ge = st.wdata[`DCS_GE_BIT];
          end
          // Hardware entry reason wins over software write
          if (st.wstrb[0] && !next_st.exc) begin
            next_st.moe = st.wdata[`DCS_MOE_LSB +: 3];
          end
        end
        `OFS_LINK_CTL, `OFS_INBOUND: begin
          // Link flags are not written directly; see below
        end
        default: begin
          next_st.bresp = `RESP_SLVERR;
        end
      endcase
    end

    // RQ23 control write clears lost
    if (ctl_wr) begin
      next_st.lost = 1'b0;
    end
    // RQ19 handler read clears full
    if (inb_rd) begin
      next_st.full = 1'b0;
    end
    // Debugger update; a new word wins over a clear in the same cycle
    // RQ20 download sets full and flag
    if (link_wr) begin
      // RQ22 download follows debugger
      next_st.dl = st.shreg[`SH_DL_BIT];
      if (st.shreg[`SH_VALID_BIT]) begin
        // RQ18 write sets full
        next_st.full    = 1'b1;
        next_st.inbound = st.shreg[`SH_DATA_LSB +: 32];
        // RQ21 overwrite of unread word
        if (st.full && !inb_rd) begin
          next_st.lost = 1'b1;
        end
      end
    end

    // Read channel
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.ar_rdy) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = `RESP_OKAY;
      case (s_axi_araddr[7:0])
        `OFS_CMP0: begin
          next_st.rdata = st.cmp0;
        end
        `OFS_CMP1: begin
          next_st.rdata = st.cmp1;
        end
        `OFS_BRK_CTL: begin
          next_st.rdata = `RST_WORD;
          next_st.rdata[`BRK_E0_LSB +: 2] = st.e0;
          next_st.rdata[`BRK_E1_LSB +: 2] = st.e1;
          next_st.rdata[`BRK_MASK_BIT]    = st.mask_mode;
        end
        `OFS_DBG_CTL: begin
          next_st.rdata = `RST_WORD;
          next_st.rdata[`DCS_GE_BIT]       = st.ge;
          next_st.rdata[`DCS_MOE_LSB +: 3] = st.moe;
        end
        `OFS_LINK_CTL: begin
          // RQ16 flags on condition bits
          next_st.rdata = `RST_WORD;
          // RQ15 handler side flags
          next_st.rdata[`LNK_FULL_BIT] = st.full;
          next_st.rdata[`LNK_LOST_BIT] = st.lost;
          next_st.rdata[`LNK_DL_BIT]   = st.dl;
        end
        `OFS_INBOUND: begin
          next_st.rdata = st.inbound;
        end
        default: begin
          next_st.rdata = `RST_WORD;
          next_st.rresp = `RESP_SLVERR;
        end
      endcase
    end

    // Ready flags, registered so every output comes from a flop
    next_st.aw_rdy = !next_st.aw_have && !next_st.bvalid;
    next_st.w_rdy  = !next_st.w_have && !next_st.bvalid;
    next_st.ar_rdy = !next_st.rvalid;
  end

  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign dbg_exception = st.exc;
  assign return_link   = st.ret_link;
  assign link_tdo      = st.tdo;
  assign s_axi_awready = st.aw_rdy;
  assign s_axi_wready  = st.w_rdy;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.ar_rdy;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;

  // Checks on the block's own behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_MOE_ON_BREAK: assert property ( // RQ12
    data_hit |=> dbg_exception && (st.moe == `MOE_DATA))
    else $error("data break did not raise exception with data reason");

  AST_RETURN_LINK: assert property ( // RQ13
    data_hit |=> (return_link == $past(acc.next_pc) + `LINK_OFS))
    else $error("return link is not next pc plus four");

  AST_PRELOAD_QUIET: assert property ( // RQ8
    acc.valid && !acc.soft_break && (acc.kind == dbg_pkg::ACC_PRELOAD) |=> !dbg_exception)
    else $error("preload access raised an exception");

  AST_SWAP_LOAD_ONLY: assert property ( // RQ9
    acc.valid && !acc.soft_break && (acc.kind == dbg_pkg::ACC_SWAP) &&
    (st.e0 == `ATYPE_LOAD) && (st.mask_mode || (st.e1 == `ATYPE_OFF) ||
    (st.e1 == `ATYPE_LOAD)) |=> !dbg_exception)
    else $error("swap fired a load-only breakpoint");

  AST_SOFT_NOP: assert property ( // RQ14
    acc.soft_break && !st.ge && !data_hit |=> !dbg_exception)
    else $error("soft break fired with debug disabled");

  AST_FULL_ON_WRITE: assert property ( // RQ18
    link_wr && st.shreg[`SH_VALID_BIT] |=> st.full ##1 st.full || $past(inb_rd))
    else $error("inbound full not set by debugger write");

  AST_READ_CLEARS: assert property ( // RQ19
    inb_rd && !link_wr |=> !st.full)
    else $error("handler read did not clear inbound full");

  AST_OVERFLOW_SET: assert property ( // RQ21
    link_wr && st.shreg[`SH_VALID_BIT] && st.full && !inb_rd |=> st.lost)
    else $error("overwrite of unread word did not set lost flag");

  AST_LOST_STICKY: assert property ( // RQ23
    st.lost && !ctl_wr |=> st.lost)
    else $error("lost flag dropped without control write");

  COV_DATA_BREAK: cover property (slot0_hit ##1 dbg_exception);
  COV_MASK_BREAK: cover property (st.mask_mode && slot0_hit);
  COV_OVERFLOW:   cover property (!st.lost ##1 st.lost);
  COV_DOWNLOAD:   cover property (st.dl && inb_rd);

endmodule

// ### logic/dbg_cfg.svh
`ifndef DBG_CFG_SVH
`define DBG_CFG_SVH

// Register byte offsets on the AXI4-Lite bus
`define OFS_CMP0        8'h00
`define OFS_CMP1        8'h04
`define OFS_BRK_CTL     8'h08
`define OFS_DBG_CTL     8'h0C
`define OFS_LINK_CTL    8'h10
`define OFS_INBOUND     8'h14

// Break control field positions
`define BRK_E0_LSB      0
`define BRK_E1_LSB      2
`define BRK_MASK_BIT    8

// Debug control and status field positions
`define DCS_GE_BIT      31
`define DCS_MOE_LSB     2

// Link control flag positions, one per condition flag
`define LNK_FULL_BIT    31
`define LNK_LOST_BIT    30
`define LNK_DL_BIT      29

// Access type encodings of a slot
`define ATYPE_OFF       2'h0
`define ATYPE_STORE     2'h1
`define ATYPE_ANY       2'h2
`define ATYPE_LOAD      2'h3

// Entry reason codes
`define MOE_NONE        3'h0
`define MOE_DATA        3'h2
`define MOE_SOFT        3'h3

// Return link offset
`define LINK_OFS        32'h0000_0004

// Inbound shift register fields
`define SH_VALID_BIT    0
`define SH_DL_BIT       1
`define SH_DATA_LSB     2

// AXI responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// Reset values
`define RST_WORD        32'h0000_0000
`define RST_PINS        5'h00

`endif

// ### logic/dbg_pkg.sv
package dbg_pkg;

  // Kind of memory access issued by the core
  typedef enum logic [2:0] {
    ACC_LOAD,
    ACC_STORE,
    ACC_SWAP,
    ACC_PRELOAD,
    ACC_CP_MAINT
  } acc_kind_e;

  // One issued access, plus the software break instruction strobe
  typedef struct packed {
    logic        valid;
    acc_kind_e   kind;
    logic [31:0] addr;
    logic [1:0]  size;
    logic [31:0] next_pc;
    logic        soft_break;
  } acc_s;

  // Test port pins, all from outside the clock domain
  typedef struct packed {
    logic tck;
    logic tdi;
    logic sel;
    logic cap;
    logic upd;
  } pin_s;

  // Whole state of the block
  typedef struct packed {
    logic [31:0] cmp0;
    logic [31:0] cmp1;
    logic [1:0]  e0;
    logic [1:0]  e1;
    logic        mask_mode;
    logic        ge;
    logic [2:0]  moe;
    logic        exc;
    logic [31:0] ret_link;
    logic        full;
    logic        lost;
    logic        dl;
    logic [31:0] inbound;
    pin_s        s1;
    pin_s        s2;
    pin_s        s3;
    pin_s        stable;
    logic [33:0] shreg;
    logic        tdo;
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        aw_rdy;
    logic        w_rdy;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        ar_rdy;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_s;

endpackage

// ### dv/dbg_host.sv
`timescale 1ns/1ns

// Debugger on the far side of the test port
module dbg_host (
  output      dbg_pkg::pin_s pins,
  input  wire logic          link_tdo
);
  // Test clock idles low outside frames
  initial pins = '0;

  // One 125 ns test clock period
  task automatic pulse;
    #63 pins.tck <= 1'b1;
    #62 pins.tck <= 1'b0;
  endtask

  // Capture and shift out the full and lost flags
  task automatic peek(output logic full, output logic lost);
    pins.sel <= 1'b1;
    pins.cap <= 1'b1;
    pulse;
    pins.cap <= 1'b0;
    full = link_tdo;
    pulse;
    lost = link_tdo;
    pins.sel <= 1'b0;
    // Idle gap so the next access never reselects in the same step
    #125;
  endtask

  // Shift a 34-bit frame in first bit first, then update
  task automatic frame(input logic [31:0] data, input logic dl, input logic valid);
    logic [33:0] f;
    f = {data, dl, valid};
    pins.sel <= 1'b1;
    for (int i = 0; i < 34; i++) begin
      pins.tdi <= f[i];
      pulse;
    end
    pins.upd <= 1'b1;
    pulse;
    pins.upd <= 1'b0;
    pins.sel <= 1'b0;
    // Released data line must not keep its last level
    pins.tdi <= ~f[33];
    // Idle gap so back to back frames never reselect in the same step
    #125;
  endtask

  task automatic send(input logic [31:0] data);
    logic full;
    logic lost;
    do peek(full, lost); while (full !== 1'b0);
    frame(data, 1'b0, 1'b1);
  endtask

  task automatic download(input logic [31:0] base, input int n);
    logic full;
    logic lost;
    do peek(full, lost); while (full !== 1'b0);
    for (int i = 0; i < n; i++) begin
      frame(base + 32'(i), 1'b1, 1'b1);
    end
  endtask

  task automatic finish_download;
    frame(32'h0000_0000, 1'b0, 1'b0);
  endtask
endmodule

// ### dv/tb.sv
`timescale 1ns/1ns
`include "dbg_cfg.svh"

module tb;
  logic          clock;
  logic          arst_n;
  dbg_pkg::acc_s acc;
  dbg_pkg::pin_s pins;
  logic          dbg_exception;
  logic [31:0]   return_link;
  logic          link_tdo;
  logic [31:0]   s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]    s_axi_wstrb;
  logic [1:0]    s_axi_bresp, s_axi_rresp;
  logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic          s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic          s_axi_rvalid, s_axi_rready;
  int            errors = 0;
  int            n_checks = 0;
  int            cycles = 0;
  logic [31:0]   pc = 32'h0000_4000;
  logic          f, l;

  data_break_link i_data_break_link (
    .clock, .arst_n, .acc, .dbg_exception, .return_link, .pins, .link_tdo,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );

  dbg_host i_dbg_host (.pins, .link_tdo);

  // Core clock, 10 ns
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors++;
      test_done;
    end
  end

  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge clock);
    s_axi_awaddr <= {24'h00_0000, a};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  // Bus read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clock);
    s_axi_araddr <= {24'h00_0000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, exp);
    check({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  // One access or soft break, then look for the exception pulse
  task automatic hit(input dbg_pkg::acc_kind_e k, input logic [31:0] a, input logic [1:0] sz,
                     input logic sb, input logic exp);
    @(posedge clock);
    acc <= '{valid: ~sb, kind: k, addr: a, size: sz, next_pc: pc, soft_break: sb};
    @(posedge clock);
    acc <= '0;
    #1;
    check({31'h0, dbg_exception}, {31'h0, exp});
    if (exp) check(return_link, pc + `LINK_OFS);
    pc = pc + 32'h0000_0010;
  endtask

  initial begin
    arst_n = 1'b0;
    acc = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    rd(`OFS_BRK_CTL, 32'h0, `RESP_OKAY);
    rd(`OFS_LINK_CTL, 32'h0, `RESP_OKAY);
    rd(8'h20, 32'h0, `RESP_SLVERR);
    wr(8'h24, 32'h1, `RESP_SLVERR);
    wr(`OFS_CMP0, 32'hA5A5_5A5A, `RESP_OKAY);
    rd(`OFS_CMP0, 32'hA5A5_5A5A, `RESP_OKAY);
    wr(`OFS_CMP1, 32'h5A5A_A5A5, `RESP_OKAY);
    rd(`OFS_CMP1, 32'h5A5A_A5A5, `RESP_OKAY);
    // Word loads under both load-capable types
    wr(`OFS_CMP0, 32'h1000_0004, `RESP_OKAY);
    for (int t = 2; t < 4; t++) begin
      wr(`OFS_BRK_CTL, 32'(t), `RESP_OKAY);
      hit(dbg_pkg::ACC_LOAD, 32'h1000_0004, 2'h2, 1'b0, 1'b1);
      rd(`OFS_DBG_CTL, 32'h0000_0008, `RESP_OKAY);
    end
    hit(dbg_pkg::ACC_STORE, 32'h1000_0004, 2'h2, 1'b0, 1'b0);
    hit(dbg_pkg::ACC_SWAP, 32'h1000_0004, 2'h2, 1'b0, 1'b0);
    wr(`OFS_BRK_CTL, 32'h0000_0001, `RESP_OKAY);
    hit(dbg_pkg::ACC_SWAP, 32'h1000_0004, 2'h0, 1'b0, 1'b1);
    hit(dbg_pkg::ACC_LOAD, 32'h1000_0004, 2'h2, 1'b0, 1'b0);
    wr(`OFS_BRK_CTL, 32'h0000_0002, `RESP_OKAY);
    hit(dbg_pkg::ACC_PRELOAD, 32'h1000_0004, 2'h2, 1'b0, 1'b0);
    hit(dbg_pkg::ACC_CP_MAINT, 32'h1000_0004, 2'h2, 1'b0, 1'b0);
    hit(dbg_pkg::ACC_LOAD, 32'h1000_0006, 2'h2, 1'b0, 1'b1);
    hit(dbg_pkg::ACC_LOAD, 32'h1000_0003, 2'h2, 1'b0, 1'b0);
    hit(dbg_pkg::ACC_LOAD, 32'h1000_0005, 2'h0, 1'b0, 1'b0);
    hit(dbg_pkg::ACC_STORE, 32'h1000_0004, 2'h1, 1'b0, 1'b1);
    // Mask mode, slot 1 enable ignored
    wr(`OFS_CMP0, 32'h2000_0000, `RESP_OKAY);
    wr(`OFS_CMP1, 32'h0000_00F0, `RESP_OKAY);
    wr(`OFS_BRK_CTL, 32'h0000_010A, `RESP_OKAY);
    hit(dbg_pkg::ACC_LOAD, 32'h2000_0080, 2'h0, 1'b0, 1'b1);
    hit(dbg_pkg::ACC_LOAD, 32'h2000_0100, 2'h0, 1'b0, 1'b0);
    hit(dbg_pkg::ACC_LOAD, 32'h0000_00F0, 2'h0, 1'b0, 1'b0);
    wr(`OFS_BRK_CTL, 32'h0000_0108, `RESP_OKAY);
    hit(dbg_pkg::ACC_LOAD, 32'h2000_0080, 2'h0, 1'b0, 1'b0);
    // Second address slot on its own
    wr(`OFS_CMP1, 32'h3000_0000, `RESP_OKAY);
    wr(`OFS_BRK_CTL, 32'h0000_0004, `RESP_OKAY);
    hit(dbg_pkg::ACC_STORE, 32'h3000_0000, 2'h0, 1'b0, 1'b1);
    hit(dbg_pkg::ACC_LOAD, 32'h3000_0000, 2'h0, 1'b0, 1'b0);
    hit(dbg_pkg::ACC_STORE, 32'h2000_0000, 2'h0, 1'b0, 1'b0);
    // Soft break gated by global enable
    hit(dbg_pkg::ACC_LOAD, 32'h0, 2'h0, 1'b1, 1'b0);
    wr(`OFS_DBG_CTL, 32'h8000_0000, `RESP_OKAY);
    hit(dbg_pkg::ACC_LOAD, 32'h0, 2'h0, 1'b1, 1'b1);
    rd(`OFS_DBG_CTL, 32'h8000_000C, `RESP_OKAY);
    // Normal handshake over the test port
    i_dbg_host.send(32'hC3C3_1234);
    rd(`OFS_LINK_CTL, 32'h8000_0000, `RESP_OKAY);
    i_dbg_host.peek(f, l);
    check({30'h0, l, f}, 32'h0000_0001);
    rd(`OFS_INBOUND, 32'hC3C3_1234, `RESP_OKAY);
    rd(`OFS_LINK_CTL, 32'h0, `RESP_OKAY);
    // Download, one word then an overrun
    i_dbg_host.download(32'h1111_2222, 1);
    rd(`OFS_LINK_CTL, 32'hA000_0000, `RESP_OKAY);
    rd(`OFS_INBOUND, 32'h1111_2222, `RESP_OKAY);
    rd(`OFS_LINK_CTL, 32'h2000_0000, `RESP_OKAY);
    i_dbg_host.download(32'h3333_4444, 2);
    rd(`OFS_LINK_CTL, 32'hE000_0000, `RESP_OKAY);
    rd(`OFS_INBOUND, 32'h3333_4445, `RESP_OKAY);
    rd(`OFS_LINK_CTL, 32'h6000_0000, `RESP_OKAY);
    i_dbg_host.finish_download;
    rd(`OFS_LINK_CTL, 32'h4000_0000, `RESP_OKAY);
    wr(`OFS_LINK_CTL, 32'h0, `RESP_OKAY);
    rd(`OFS_LINK_CTL, 32'h0, `RESP_OKAY);
    test_done;
  end
endmodule
